// ==== radio_power_reset_supervisor.sv ====
// supervisor that runs the radio from the host's on/off line
// assumes the on/off line and the shutdown strobe are asynchronous pins
`timescale 1ns/100ps
module radio_power_reset_supervisor #(
  parameter logic [radio_supervisor_pkg::CNT_W-1:0] SHORT_CYCLES =
    radio_supervisor_pkg::SHORT_CYC,
  parameter logic [radio_supervisor_pkg::CNT_W-1:0] LONG_CYCLES =
    radio_supervisor_pkg::LONG_CYC,
  parameter logic [radio_supervisor_pkg::CNT_W-1:0] RESTART_CYCLES =
    radio_supervisor_pkg::RESTART_CYC,
  parameter logic [radio_supervisor_pkg::CNT_W-1:0] RESET_CYCLES =
    radio_supervisor_pkg::RESET_PULSE_CYC
)
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic radio_power_ctrl_n,
  input wire logic radio_shutdown_cmd,
  input wire logic module_reset_n,
  output logic cpu_reset_n,
  output logic radio_on,
  output logic radio_reset_n,
  output logic radio_rail_monitor
);
  import radio_supervisor_pkg::*;

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic ctrlMeta;
  logic ctrlSync;
  logic shdnMeta;
  logic shdnSync;
  logic shdnPrev;
  logic next_ctrlMeta;
  logic next_ctrlSync;
  logic next_shdnMeta;
  logic next_shdnSync;
  logic next_shdnPrev;

  // plain copies; the first stage is read only by the second
  always_comb begin
    next_ctrlMeta = radio_power_ctrl_n;
    next_ctrlSync = ctrlMeta;
    next_shdnMeta = radio_shutdown_cmd;
    next_shdnSync = shdnMeta;
    next_shdnPrev = shdnSync;
  end

  // idle levels after reset, so no false edge follows release
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrlMeta <= CTRL_IDLE;
      ctrlSync <= CTRL_IDLE;
      shdnMeta <= SHDN_IDLE;
      shdnSync <= SHDN_IDLE;
      shdnPrev <= SHDN_IDLE;
    end else begin
      ctrlMeta <= next_ctrlMeta;
      ctrlSync <= next_ctrlSync;
      shdnMeta <= next_shdnMeta;
      shdnSync <= next_shdnSync;
      shdnPrev <= next_shdnPrev;
    end
  end

  logic shdnRise;
  assign shdnRise = shdnSync & ~shdnPrev;

  // ****************************************
  // processor reset
  // ****************************************
  // flop keeps the output registered; one cycle of delay is harmless
  // next to a pulse of at least 200 us
  logic next_cpuReset;
  assign next_cpuReset = module_reset_n; // R10

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cpu_reset_n <= CPU_RST_N_RST;
    end else begin
      cpu_reset_n <= next_cpuReset; // R10
    end
  end

  // ****************************************
  // count comparisons
  // ****************************************
  // strict compare: a pulse must outlast the limit to count
  function automatic logic past_limit(
    input logic [CNT_W-1:0] cnt,
    input logic [CNT_W-1:0] limit
  );
    return cnt > limit;
  endfunction

  // reset and shutdown states leave as soon as their limit is reached
  function automatic logic at_limit(
    input logic [CNT_W-1:0] cnt,
    input logic [CNT_W-1:0] limit
  );
    return cnt >= limit;
  endfunction

  // ****************************************
  // control state machine
  // ****************************************
  sup_state_t state;
  sup_state_t next_state;
  logic [CNT_W-1:0] count;
  logic clear;
  logic next_radioOn;
  logic next_radioResetN;
  logic next_monitor;

  // the count restarts at every state change
  cycle_counter cycle_counter_inst (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clear(clear),
    .count(count)
  );

  always_comb begin
    next_state = state;
    clear = 1'b0;
    case (state)
      ST_RUN: begin
        if (!ctrlSync) begin
          next_state = ST_LOW;
          clear = 1'b1;
        end else if (shdnRise) begin
          next_state = ST_SHDN;
          clear = 1'b1;
        end
      end
      ST_LOW: begin
        // the long limit acts while the line is still held low
        if (past_limit(count, LONG_CYCLES)) begin
          next_state = ST_OFF; // R2
          clear = 1'b1;
        end else if (ctrlSync) begin
          if (past_limit(count, SHORT_CYCLES)) begin
            next_state = ST_RESET; // R1
          end else begin
            next_state = ST_RUN; // R11
          end
          clear = 1'b1;
        end
      end
      ST_RESET: begin
        // one pulse length serves both a reset and a wake from off
        if (at_limit(count, RESET_CYCLES)) begin
          next_state = ST_RUN;
          clear = 1'b1;
        end
      end
      ST_OFF: begin
        // a rising line wakes the radio through a reset pulse
        if (ctrlSync) begin
          next_state = ST_RESET; // R7
          clear = 1'b1;
        end
      end
      ST_SHDN: begin
        // the host may drop supply any time after 30 s
        if (!ctrlSync) begin
          next_state = ST_OFF; // R6
          clear = 1'b1;
        end else if (at_limit(count, RESTART_CYCLES)) begin
          next_state = ST_RESET; // R4
          clear = 1'b1;
        end
      end
      default: begin
        next_state = ST_RUN;
        clear = 1'b1;
      end
    endcase
  end

  // ****************************************
  // radio outputs
  // ****************************************
  // decoded from next_state so outputs land with the state register
  always_comb begin
    next_radioOn = 1'b1;
    next_radioResetN = 1'b1;
    next_monitor = 1'b1;
    case (next_state)
      ST_RESET: begin
        next_radioResetN = 1'b0; // R1
      end
      ST_OFF: begin
        next_radioOn = 1'b0; // R6
        next_monitor = 1'b0; // R5
      end
      ST_SHDN: begin
        next_radioOn = 1'b0;
        next_monitor = 1'b0;
      end
      default: begin
        next_radioOn = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= STATE_RST;
      radio_on <= RADIO_ON_RST;
      radio_reset_n <= RADIO_RST_N_RST;
      radio_rail_monitor <= MONITOR_RST;
    end else begin
      state <= next_state;
      radio_on <= next_radioOn;
      radio_reset_n <= next_radioResetN;
      radio_rail_monitor <= next_monitor;
    end
  end
endmodule

// ==== radio_supervisor_pkg.sv ====
// constants and types for the radio power and reset supervisor
// assumes a single 200 MHz clock and an active-low asynchronous reset
// How it works
// [R1] low 50 ms to 1 s resets radio
// [R2] low beyond 1 s powers radio down
// [R3] host waits 30 s after shutdown command
// [R4] after shutdown, restart after 60 s high
// [R5] monitor output low once radio is off
// [R6] radio stays off while line held low
// [R7] line going high resets and wakes radio
// [R8] host toggles line to leave sleep
// [R9] host reset pulse 200 us to 1 s
// [R10] module reset wired straight to cpu reset; code passes it through one flop, a cycle late
// [R11] low pulses under 50 ms are ignored
package radio_supervisor_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_HZ = 200_000_000;
  localparam int SHORT_MS = 50;
  localparam int LONG_MS = 1000;
  localparam int RESTART_S = 60;
  localparam int RESET_PULSE_US = 200;
  localparam int CNT_W = 34;
  localparam logic [CNT_W-1:0] SHORT_CYC =
    CNT_W'(64'(SHORT_MS) * 64'(CLK_HZ) / 64'd1000);
  localparam logic [CNT_W-1:0] LONG_CYC =
    CNT_W'(64'(LONG_MS) * 64'(CLK_HZ) / 64'd1000);
  localparam logic [CNT_W-1:0] RESTART_CYC =
    CNT_W'(64'(RESTART_S) * 64'(CLK_HZ));
  localparam logic [CNT_W-1:0] RESET_PULSE_CYC =
    CNT_W'((64'(RESET_PULSE_US) * 64'(CLK_HZ) + 64'd999_999) / 64'd1_000_000);

  // ****************************************
  // states
  // ****************************************
  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_LOW = 3'b001,
    ST_RESET = 3'b010,
    ST_OFF = 3'b011,
    ST_SHDN = 3'b100
  } sup_state_t;

  localparam logic RADIO_ON_RST = 1'b0;
  localparam logic RADIO_RST_N_RST = 1'b0;
  localparam logic MONITOR_RST = 1'b0;
  localparam logic CPU_RST_N_RST = 1'b0;
  localparam logic CTRL_IDLE = 1'b1;
  localparam logic SHDN_IDLE = 1'b0;
  localparam sup_state_t STATE_RST = ST_RESET;

endpackage

// ==== cycle_counter.sv ====
// saturating cycle counter with synchronous clear
// assumes clear and count come from the same clock domain
`timescale 1ns/100ps
module cycle_counter (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clear,
  output logic [radio_supervisor_pkg::CNT_W-1:0] count
);
  import radio_supervisor_pkg::*;

  logic [CNT_W-1:0] next_count;

  always_comb begin
    if (clear) begin
      next_count = '0;
    end else if (&count) begin
      next_count = count;
    end else begin
      next_count = count + CNT_W'(1);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end
endmodule

// ==== radio_supervisor_checker.sv ====
// assertions on the radio supervisor ports
// assumes the bench shortens the counts to the defaults below
`timescale 1ns/100ps
module radio_supervisor_checker #(
  parameter int SHORT = 20,
  parameter int LONG = 100,
  parameter int RESTART = 300
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic radio_power_ctrl_n,
  input wire logic radio_shutdown_cmd,
  input wire logic module_reset_n,
  input wire logic cpu_reset_n,
  input wire logic radio_on,
  input wire logic radio_reset_n,
  input wire logic radio_rail_monitor
);
  // slack covers the synchroniser and state register delay
  localparam int RS_LO = RESTART - 10;
  localparam int RS_HI = RESTART + 40;
  int lowCnt;
  int next_lowCnt;
  always_comb next_lowCnt = radio_power_ctrl_n ? 0 : lowCnt + 1;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) lowCnt <= 0;
    else lowCnt <= next_lowCnt;
  end
  // ********************
  // properties
  // ********************
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_cpu_reset_copy: assert property ($past(rst_n) |->
    cpu_reset_n == $past(module_reset_n)) else $error("cpu reset lag");
  a_monitor_off: assert property (!radio_on |->
    !radio_rail_monitor) else $error("monitor high while off");
  a_stay_off: assert property ($fell(radio_on) &&
    !radio_power_ctrl_n |=> !radio_on [*8]) else $error("woke early");
  a_long_off: assert property (lowCnt == LONG + 8 |->
    !radio_on && !radio_rail_monitor) else $error("no power down");
  a_short_ignored: assert property ($rose(radio_power_ctrl_n) &&
    lowCnt < SHORT - 2 && radio_on && radio_reset_n |->
    radio_reset_n [*8]) else $error("short pulse acted");
  a_mid_reset: assert property ($rose(radio_power_ctrl_n) &&
    lowCnt > SHORT + 3 && lowCnt < LONG - 3 && radio_on |->
    ##[1:6] !radio_reset_n) else $error("no radio reset");
  a_high_wakes: assert property ($rose(radio_power_ctrl_n) &&
    !radio_on |-> ##[1:30] (radio_on && radio_reset_n))
    else $error("no wake");
  a_shdn_restart: assert property (
    disable iff (!rst_n || !radio_power_ctrl_n)
    $rose(radio_shutdown_cmd) &&
    radio_on && radio_reset_n |-> ##[1:6] !radio_on
    ##[RS_LO:RS_HI] (radio_on && radio_reset_n)) else $error("restart");
endmodule

// ==== host_model.sv ====
// host side: on/off line, shutdown strobe, module reset pin
// assumes the bench calls its tasks; changes land on falling edges
`timescale 1ns/100ps
module host_model (
  input wire logic clk_sys,
  output logic ctrlN,
  output logic shdnCmd,
  output logic modRstN
);
  initial begin
    ctrlN = 1'b1;
    shdnCmd = 1'b0;
    modRstN = 1'b1;
  end
  task automatic hold_low(input int n);
    @(negedge clk_sys) ctrlN = 1'b0;
    repeat (n) @(negedge clk_sys);
    ctrlN = 1'b1;
  endtask
  // power stays applied, so the restart path runs
  task automatic shutdown();
    @(negedge clk_sys) shdnCmd = 1'b1;
    repeat (4) @(negedge clk_sys);
    shdnCmd = 1'b0;
  endtask
  task automatic pulse_reset(input int n);
    @(negedge clk_sys) modRstN = 1'b0;
    repeat (n) @(negedge clk_sys);
    modRstN = 1'b1;
  endtask
endmodule

// ==== testbench.sv ====
// self-checking bench for the radio supervisor
// assumes counts shortened to 20, 100, 300 and 10 cycles
`timescale 1ns/100ps
module testbench;
  logic clk_sys, rst_n, ctrlN, shdnCmd, modRstN;
  logic cpuRstN, radioOn, radioRstN, monitor;
  int errCount = 0;
  int comparisons = 0;
  int cycles = 0;
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  radio_power_reset_supervisor #(.SHORT_CYCLES(34'h14),
    .LONG_CYCLES(34'h64), .RESTART_CYCLES(34'h12c),
    .RESET_CYCLES(34'ha)) radio_power_reset_supervisor_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .radio_power_ctrl_n(ctrlN),
    .radio_shutdown_cmd(shdnCmd), .module_reset_n(modRstN),
    .cpu_reset_n(cpuRstN), .radio_on(radioOn),
    .radio_reset_n(radioRstN), .radio_rail_monitor(monitor));
  host_model host_model_inst (.clk_sys(clk_sys), .ctrlN(ctrlN),
    .shdnCmd(shdnCmd), .modRstN(modRstN));
  task automatic check(input logic seen, input logic want);
    comparisons++;
    if (seen !== want) begin
      errCount++;
      $display("MISMATCH at %0t: saw %b want %b", $time, seen, want);
    end
  endtask
  task automatic giveVerdict();
    $display("mismatches %0d, checks %0d", errCount, comparisons);
    if (errCount == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // ********************
  // scenarios
  // ********************
  task automatic t_cpu_reset();
    fork host_model_inst.pulse_reset(40); join_none
    wait_n(3);
    check(cpuRstN, 1'b0);
    wait_n(40);
    check(cpuRstN, 1'b1);
  endtask
  task automatic t_short_mid();
    host_model_inst.hold_low(15);
    wait_n(8);
    check(radioRstN, 1'b1);
    host_model_inst.hold_low(50);
    wait_n(5);
    check(radioRstN, 1'b0);
    wait_n(20);
    check(radioOn && radioRstN, 1'b1);
  endtask
  task automatic t_long();
    fork host_model_inst.hold_low(150); join_none
    wait_n(125);
    check(radioOn || monitor, 1'b0);
    wait_n(20);
    check(radioOn, 1'b0);
    wait_n(35);
    check(radioOn && radioRstN, 1'b1);
  endtask
  task automatic t_shutdown();
    host_model_inst.shutdown();
    wait_n(3);
    check(radioOn || monitor, 1'b0);
    wait_n(280);
    check(radioOn, 1'b0);
    wait_n(60);
    check(radioOn && radioRstN, 1'b1);
  endtask
  // line low after shutdown powers off; long enough to pass restart
  task automatic t_shutdown_low();
    host_model_inst.shutdown();
    host_model_inst.hold_low(320);
    check(radioOn || monitor, 1'b0);
    wait_n(3);
    host_model_inst.shutdown();
    wait_n(30);
    check(radioOn && radioRstN && monitor, 1'b1);
  endtask
  task automatic t_mid_reset();
    rst_n = 1'b0;
    wait_n(2);
    check(cpuRstN, 1'b0);
    check(radioOn || monitor, 1'b0);
    rst_n = 1'b1;
    wait_n(20);
    check(radioOn && radioRstN && monitor, 1'b1);
    check(cpuRstN, 1'b1);
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 4000) begin
      errCount++;
      giveVerdict();
    end
  end
  initial begin
    rst_n = 1'b0;
    wait_n(10);
    rst_n = 1'b1;
    wait_n(20);
    check(radioOn && radioRstN && monitor, 1'b1);
    t_cpu_reset();
    t_short_mid();
    t_long();
    t_shutdown();
    t_shutdown_low();
    t_mid_reset();
    giveVerdict();
  end
endmodule
bind radio_power_reset_supervisor radio_supervisor_checker
  radio_supervisor_checker_inst (.clk_sys(clk_sys), .rst_n(rst_n),
  .radio_power_ctrl_n(radio_power_ctrl_n),
  .radio_shutdown_cmd(radio_shutdown_cmd),
  .module_reset_n(module_reset_n), .cpu_reset_n(cpu_reset_n),
  .radio_on(radio_on), .radio_reset_n(radio_reset_n),
  .radio_rail_monitor(radio_rail_monitor));
